// ===== rtl/fpwm_cfg.svh
// Constants for the fan PWM controller: timing, duty units, register map
`ifndef FPWM_CFG_SVH_CFG
`define FPWM_CFG_SVH_CFG
`define FPWM_CLK_HZ        250000000
`define FPWM_PWM_HZ        30
`define FPWM_START_MS      1000
`define FPWM_GATE_MS       1000
`define FPWM_RPM_PER_PULSE 30
`define FPWM_DUTY_FULL     9'h12c
`define FPWM_DUTY_MIN      9'h05a
`define FPWM_DUTY_STEP     9'h00e
`define FPWM_DUTY_OPEN     9'h076
`define FPWM_TEMP_LO       8'h67
`define FPWM_TEMP_HI       8'ha6
`define FPWM_THR_RST       16'h0100
`define FPWM_OFS_CFG       6'h00
`define FPWM_OFS_STAT      6'h04
`define FPWM_OFS_DUTY      6'h08
`define FPWM_OFS_THR       6'h0c
`define FPWM_OFS_RPM       6'h10
`define FPWM_BIT_SHDN      0
`define FPWM_BIT_SRC       5
`define FPWM_BIT_FF        0
`define FPWM_BIT_OT        5
`endif

// ===== rtl/fpwm_ctrl.sv
// Fan PWM drive with startup interval, duty source select and fault output
// What this block does
// - Fault output goes low while measured fan speed is below threshold.
// - Over-temperature variant also holds fault low during over-temperature.
// - Temperature above upper limit sets status bit 5.
// - Tach pulses are counted per gate window and scaled to RPM.
// - PWM output is active high, driven both ways.
// - Period is fixed; only the high time changes.
// - Commanded duty always lies between 30 and 100 percent.
// - Default period gives a 30 Hz output.
// - High time equals duty fraction times the period.
// - At full duty the output never goes low outside shutdown.
// - Full duty for one second after reset and after shutdown.
// - After startup the source select bit picks the duty source.
// - Reset selects the temperature level as duty source.
// - Open temperature input gives 39.33 percent duty.
// - Period should stay between 15 and 35 Hz; advisory only.
// - Temperature low to high limit maps to 30 to 100 percent.
// - Host 4-bit code picks one of sixteen even steps.
// - Output stops only when the shutdown bit is set.
// - Locked rotor does not stop the pulses.
`include "fpwm_cfg.svh"
module fpwm_ctrl import fpwm_pkg::*; #(
    // default gives 30 Hz; keep within 15..35 Hz
    parameter int unsigned PERIOD_CYC    = `FPWM_CLK_HZ / `FPWM_PWM_HZ,
    parameter int unsigned START_CYC     =
        `FPWM_CLK_HZ / 1000 * `FPWM_START_MS,
    parameter int unsigned GATE_CYC      =
        `FPWM_CLK_HZ / 1000 * `FPWM_GATE_MS,
    parameter int unsigned RPM_PER_PULSE = `FPWM_RPM_PER_PULSE,
    parameter bit          OT_ON_FAULT   = 1'b1,
    parameter logic [7:0]  TEMP_LO       = `FPWM_TEMP_LO,
    parameter logic [7:0]  TEMP_HI       = `FPWM_TEMP_HI
) (
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [7:0]  temp_level_in,
    input  wire logic        temp_open_in,
    input  wire logic        tach_in,
    output logic             pwm_drive_out,
    output logic             fan_fault_n_out
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam logic [31:0] PER_LAST   = 32'(PERIOD_CYC - 1);
    localparam logic [31:0] START_LAST = 32'(START_CYC - 1);
    localparam logic [31:0] GATE_LAST  = 32'(GATE_CYC - 1);
    localparam logic [8:0]  D_SPAN     = `FPWM_DUTY_FULL - `FPWM_DUTY_MIN;
    localparam logic [7:0]  T_SPAN     = TEMP_HI - TEMP_LO;

    fpwm_state_type state_q;
    fpwm_state_type state_d;
    fpwm_cfg_type   cfg_q;
    logic [31:0]    pcnt_q;
    logic [31:0]    scnt_q;
    logic [31:0]    gcnt_q;
    logic [8:0]     duty_q;
    logic           pwm_q;
    logic           fault_n_q;
    logic           ot_q;
    logic           ff_q;
    logic [15:0]    pulse_q;
    logic [15:0]    rpm_q;
    logic [2:0]     tach_sync_q;
    logic           wait_q;
    logic [31:0]    rdata_q;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire        req      = avs_read | avs_write;
    wire        wr_commit = avs_write & ~wait_q;
    wire [31:0] be_mask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                            {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire        hit_cfg  = avs_address == `FPWM_OFS_CFG;
    wire        hit_stat = avs_address == `FPWM_OFS_STAT;
    wire        hit_duty = avs_address == `FPWM_OFS_DUTY;
    wire        hit_thr  = avs_address == `FPWM_OFS_THR;
    wire        hit_rpm  = avs_address == `FPWM_OFS_RPM;

    wire [31:0] cfg_word  = (32'(cfg_q.shdn) << `FPWM_BIT_SHDN) |
                            (32'(cfg_q.src) << `FPWM_BIT_SRC);
    wire [31:0] stat_word = (32'(ff_q) << `FPWM_BIT_FF) |
                            (32'(ot_q) << `FPWM_BIT_OT);
    wire [31:0] duty_word = {28'h0000000, cfg_q.code};
    wire [31:0] thr_word  = {16'h0000, cfg_q.thr};
    wire [31:0] rpm_word  = {16'h0000, rpm_q};

    // Unmapped offsets read as zero; writes to them are dropped
    wire [31:0] rd_mux = hit_cfg  ? cfg_word  :
                         hit_stat ? stat_word :
                         hit_duty ? duty_word :
                         hit_thr  ? thr_word  :
                         hit_rpm  ? rpm_word  : 32'h00000000;
    wire [31:0] old_word = hit_cfg ? cfg_word :
                           hit_duty ? duty_word : thr_word;
    wire [31:0] new_word = (old_word & ~be_mask) |
                           (avs_writedata & be_mask);

    // ------------------------------------------------------------
    // Duty selection
    // ------------------------------------------------------------
    wire [7:0]  t_off   = temp_level_in - TEMP_LO;
    wire [15:0] t_scl   = (16'(t_off) * 16'(D_SPAN)) / 16'(T_SPAN);
    wire [8:0]  t_duty  = temp_open_in ? `FPWM_DUTY_OPEN :
                          (temp_level_in <= TEMP_LO) ? `FPWM_DUTY_MIN :
                          (temp_level_in >= TEMP_HI) ? `FPWM_DUTY_FULL :
                          `FPWM_DUTY_MIN + 9'(t_scl);
    wire [8:0]  h_duty  = `FPWM_DUTY_MIN +
                          9'(cfg_q.code) * `FPWM_DUTY_STEP;
    wire [8:0]  sel_duty = cfg_q.src ? h_duty : t_duty;
    // Startup forces full duty; source is only consulted in run
    wire [8:0]  duty_nxt = (state_q == FPWM_ST_RUN) ? sel_duty :
                           `FPWM_DUTY_FULL;
    wire        per_end  = pcnt_q == PER_LAST;
    // Compare scaled count with scaled duty; avoids a runtime divide
    wire        hi_phase = 40'(pcnt_q) * 40'(`FPWM_DUTY_FULL) <
                           40'(PERIOD_CYC) * 40'(duty_q);
    wire        tach_rise = tach_sync_q[1] & ~tach_sync_q[2];
    wire        gate_end  = gcnt_q == GATE_LAST;
    wire [15:0] rpm_new   = 16'(32'(pulse_q) * RPM_PER_PULSE);
    wire        ot_now    = ~temp_open_in & (temp_level_in > TEMP_HI);

    // ------------------------------------------------------------
    // Startup and shutdown sequencing
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            FPWM_ST_START: begin
                if (scnt_q == START_LAST) begin
                    state_d = FPWM_ST_RUN;
                end
            end
            FPWM_ST_RUN: begin
                state_d = FPWM_ST_RUN;
            end
            FPWM_ST_SHUT: begin
                state_d = FPWM_ST_START;
            end
        endcase
        if (cfg_q.shdn) begin
            state_d = FPWM_ST_SHUT;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_q <= FPWM_ST_START;
            scnt_q  <= 32'h00000000;
        end else begin
            state_q <= state_d;
            scnt_q  <= (state_q == FPWM_ST_START) ? scnt_q + 32'h1 :
                       32'h00000000;
        end
    end

    // ------------------------------------------------------------
    // PWM generator
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pcnt_q <= 32'h00000000;
            duty_q <= `FPWM_DUTY_FULL;
            pwm_q  <= 1'b0;
        end else if (state_q == FPWM_ST_SHUT) begin
            pcnt_q <= 32'h00000000;
            duty_q <= `FPWM_DUTY_FULL;
            pwm_q  <= 1'b0;
        end else begin
            pcnt_q <= per_end ? 32'h00000000 : pcnt_q + 32'h1;
            if (per_end) begin
                duty_q <= duty_nxt;
            end
            pwm_q  <= hi_phase;
        end
    end

    // ------------------------------------------------------------
    // Tach measurement and fault
    // ------------------------------------------------------------
    // Stage 0 feeds only stage 1; edges are taken from later stages
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tach_sync_q <= 3'h0;
            gcnt_q      <= 32'h00000000;
            pulse_q     <= 16'h0000;
            rpm_q       <= 16'h0000;
            ff_q        <= 1'b0;
            ot_q        <= 1'b0;
            fault_n_q   <= 1'b1;
        end else begin
            tach_sync_q <= {tach_sync_q[1:0], tach_in};
            gcnt_q      <= gate_end ? 32'h00000000 : gcnt_q + 32'h1;
            if (gate_end) begin
                pulse_q <= {15'h0000, tach_rise};
                rpm_q   <= rpm_new;
                ff_q    <= rpm_new < cfg_q.thr;
            end else if (tach_rise && pulse_q != 16'hffff) begin
                pulse_q <= pulse_q + 16'h1;
            end
            ot_q      <= ot_now;
            fault_n_q <= ~(ff_q | (OT_ON_FAULT & ot_q));
        end
    end

    // ------------------------------------------------------------
    // Register slave
    // ------------------------------------------------------------
    // One wait cycle per access; read data loaded as waitrequest drops
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wait_q     <= 1'b1;
            rdata_q    <= 32'h00000000;
            cfg_q.shdn <= 1'b0;
            cfg_q.src  <= 1'b0;
            cfg_q.code <= 4'h0;
            cfg_q.thr  <= `FPWM_THR_RST;
        end else begin
            wait_q <= ~(req & wait_q);
            if (req && wait_q) begin
                rdata_q <= rd_mux;
            end
            if (wr_commit && hit_cfg) begin
                cfg_q.shdn <= new_word[`FPWM_BIT_SHDN];
                cfg_q.src  <= new_word[`FPWM_BIT_SRC];
            end
            if (wr_commit && hit_duty) begin
                cfg_q.code <= new_word[3:0];
            end
            if (wr_commit && hit_thr) begin
                cfg_q.thr <= new_word[15:0];
            end
        end
    end

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;
    assign pwm_drive_out   = pwm_q;
    assign fan_fault_n_out = fault_n_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_ff_fault;
        @(posedge clk_sys) disable iff (!resetn)
        ff_q |=> !fan_fault_n_out;
    endproperty
    a_ff_fault: assert property (p_ff_fault)
        else $error("Fan fault not shown on fault pin");

    property p_ot_fault;
        @(posedge clk_sys) disable iff (!resetn)
        (OT_ON_FAULT && ot_q) |=> !fan_fault_n_out;
    endproperty
    a_ot_fault: assert property (p_ot_fault)
        else $error("Over-temperature not shown on fault pin");

    property p_ot_flag;
        @(posedge clk_sys) disable iff (!resetn)
        ot_now |=> stat_word[`FPWM_BIT_OT];
    endproperty
    a_ot_flag: assert property (p_ot_flag)
        else $error("Over-temperature flag not set");

    property p_tach_count;
        @(posedge clk_sys) disable iff (!resetn)
        (tach_rise && !gate_end && pulse_q != 16'hffff) |=>
            pulse_q == $past(pulse_q) + 16'h1;
    endproperty
    a_tach_count: assert property (p_tach_count)
        else $error("Tach pulse not counted");

    property p_duty_range;
        @(posedge clk_sys) disable iff (!resetn)
        duty_q >= `FPWM_DUTY_MIN && duty_q <= `FPWM_DUTY_FULL;
    endproperty
    a_duty_range: assert property (p_duty_range)
        else $error("Duty outside allowed range");

    property p_full_high;
        @(posedge clk_sys) disable iff (!resetn)
        (duty_q == `FPWM_DUTY_FULL && state_q != FPWM_ST_SHUT &&
         $past(state_q) != FPWM_ST_SHUT) |=> pwm_drive_out;
    endproperty
    a_full_high: assert property (p_full_high)
        else $error("Output low at full duty");

    property p_start_full;
        @(posedge clk_sys) disable iff (!resetn)
        (state_q == FPWM_ST_START) |-> duty_q == `FPWM_DUTY_FULL;
    endproperty
    a_start_full: assert property (p_start_full)
        else $error("Startup not at full duty");

    property p_stop_only_shdn;
        @(posedge clk_sys) disable iff (!resetn)
        $fell(pwm_drive_out) |->
            $past(duty_q) != `FPWM_DUTY_FULL || $past(state_q, 2) ==
            FPWM_ST_SHUT || $past(state_q) == FPWM_ST_SHUT;
    endproperty
    a_stop_only_shdn: assert property (p_stop_only_shdn)
        else $error("Output stopped without shutdown");

    property p_host_step;
        @(posedge clk_sys) disable iff (!resetn)
        (per_end && state_q == FPWM_ST_RUN && !cfg_q.shdn && cfg_q.src)
            |=> duty_q == `FPWM_DUTY_MIN +
                9'($past(cfg_q.code)) * `FPWM_DUTY_STEP;
    endproperty
    a_host_step: assert property (p_host_step)
        else $error("Host duty step wrong");

    property p_duty_boundary;
        @(posedge clk_sys) disable iff (!resetn)
        $changed(duty_q) |-> $past(per_end) ||
            $past(state_q) == FPWM_ST_SHUT;
    endproperty
    a_duty_boundary: assert property (p_duty_boundary)
        else $error("Duty changed inside a period");

    c_run: cover property (@(posedge clk_sys) disable iff (!resetn)
        state_q == FPWM_ST_START ##1 state_q == FPWM_ST_RUN);
    c_fault: cover property (@(posedge clk_sys) disable iff (!resetn)
        $fell(fan_fault_n_out));
    c_host: cover property (@(posedge clk_sys) disable iff (!resetn)
        per_end && cfg_q.src && state_q == FPWM_ST_RUN);
    c_shut: cover property (@(posedge clk_sys) disable iff (!resetn)
        state_q == FPWM_ST_SHUT ##1 state_q == FPWM_ST_START);
endmodule : fpwm_ctrl

// ===== rtl/fpwm_pkg.sv
// Types shared by the fan PWM controller
package fpwm_pkg;
    typedef enum logic [1:0] {
        FPWM_ST_START,
        FPWM_ST_RUN,
        FPWM_ST_SHUT
    } fpwm_state_type;

    typedef struct packed {
        logic        shdn;
        logic        src;
        logic [3:0]  code;
        logic [15:0] thr;
    } fpwm_cfg_type;
endpackage : fpwm_pkg

// ===== tb/fan_pwm_startup_fault_ctrl_bench.sv
// Self-checking bench for the fan PWM controller
`include "fpwm_cfg.svh"
module fan_pwm_startup_fault_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PER = 30;
    localparam int STC = 200;
    localparam int GTC = 100;
    typedef struct {
        logic       src;
        logic [3:0] code;
        logic [7:0] temp;
        logic       open;
        int         hi;
    } fpwmb_row_type;
    logic          clk_sys;
    logic          resetn;
    logic [5:0]    avs_address;
    logic          avs_read;
    logic          avs_write;
    logic [31:0]   avs_writedata;
    logic [3:0]    avs_byteenable;
    logic [31:0]   avs_readdata;
    logic          avs_waitrequest;
    logic [7:0]    temp_level_in;
    logic          temp_open_in;
    logic          tach_in;
    logic          pwm_drive_out;
    logic          fan_fault_n_out;
    logic          stall;
    logic [31:0]   q;
    int            h;
    int            cyc;
    int            failures;
    int            num_checks;
    fpwmb_row_type rows[21];

    fpwm_ctrl #(.PERIOD_CYC(PER), .START_CYC(STC), .GATE_CYC(GTC))
    fpwm_ctrl_i (.clk_sys(clk_sys), .resetn(resetn),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .temp_level_in(temp_level_in),
        .temp_open_in(temp_open_in), .tach_in(tach_in),
        .pwm_drive_out(pwm_drive_out), .fan_fault_n_out(fan_fault_n_out));
    fpwm_fan_model fpwm_fan_model_i (.clk_sys(clk_sys),
        .pwm_drive_out(pwm_drive_out), .stall(stall), .tach_out(tach_in));

    // ---------------------------------------------
    // Helpers
    // ---------------------------------------------
    function automatic int hi_of(input int d);
        return (PER * d + 299) / 300;
    endfunction : hi_of
    function automatic int tduty(input logic [7:0] t, input logic o);
        if (o) return 118;
        if (t <= `FPWM_TEMP_LO) return 90;
        if (t >= `FPWM_TEMP_HI) return 300;
        return 90 + (t - `FPWM_TEMP_LO) * 210 / (`FPWM_TEMP_HI - `FPWM_TEMP_LO);
    endfunction : tduty
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run
    // Holds the request until waitrequest is seen low at a rising edge;
    // a slave that never answers is caught by the cycle ceiling
    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        @(posedge clk_sys);
        avs_write      <= wr;
        avs_read       <= !wr;
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        do begin
            @(posedge clk_sys);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus
    task automatic hi_cnt(input int n);
        h = 0;
        repeat (n) begin
            @(negedge clk_sys);
            if (pwm_drive_out === 1'b1) h++;
        end
    endtask : hi_cnt

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // Ceiling well above the few thousand cycles the tests need
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 30000) begin
            failures++;
            complete_run();
        end
    end

    // ---------------------------------------------
    // Main sequence
    // ---------------------------------------------
    initial begin
        {avs_address, avs_read, avs_write, avs_writedata} = '0;
        avs_byteenable = 4'hf;
        resetn = 1'b0;
        temp_level_in = 8'h00;
        temp_open_in = 1'b1;
        stall = 1'b0;
        for (int k = 0; k < 16; k++) begin
            rows[k] = '{1'b1, k[3:0], 8'h00, 1'b0, hi_of(90 + 14 * k)};
        end
        rows[16] = '{1'b0, 4'hf, 8'h50, 1'b1, 0};
        rows[17] = '{1'b0, 4'hf, 8'h40, 1'b0, 0};
        rows[18] = '{1'b0, 4'hf, 8'h67, 1'b0, 0};
        rows[19] = '{1'b0, 4'hf, 8'h80, 1'b0, 0};
        rows[20] = '{1'b0, 4'hf, 8'ha6, 1'b0, 0};
        for (int k = 16; k < 21; k++) begin
            rows[k].hi = hi_of(tduty(rows[k].temp, rows[k].open));
        end
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        check(avs_readdata, 32'h0);
        check(avs_waitrequest, 1'b1);
        check(pwm_drive_out, 1'b0);
        check(fan_fault_n_out, 1'b1);
        @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        hi_cnt(STC - 10);
        check(h, STC - 10);
        bus(1'b0, `FPWM_OFS_CFG, 0, 4'hf);
        check(q, 32'h0);
        bus(1'b0, `FPWM_OFS_DUTY, 0, 4'hf);
        check(q, 32'h0);
        bus(1'b0, `FPWM_OFS_THR, 0, 4'hf);
        check(q, {16'h0, `FPWM_THR_RST});
        bus(1'b1, 6'h14, 32'hffff_ffff, 4'hf);
        bus(1'b0, 6'h14, 0, 4'hf);
        check(q, 32'h0);
        bus(1'b1, `FPWM_OFS_THR, 32'h0000_0005, 4'h0);
        bus(1'b0, `FPWM_OFS_THR, 0, 4'hf);
        check(q, {16'h0, `FPWM_THR_RST});
        foreach (rows[i]) begin
            @(posedge clk_sys);
            temp_level_in <= rows[i].temp;
            temp_open_in  <= rows[i].open;
            bus(1'b1, `FPWM_OFS_DUTY, {28'h0, rows[i].code}, 4'hf);
            bus(1'b1, `FPWM_OFS_CFG, {26'h0, rows[i].src, 5'h0}, 4'hf);
            repeat (2 * PER + 5) @(posedge clk_sys);
            hi_cnt(2 * PER);
            check(h, 2 * rows[i].hi);
        end
        bus(1'b1, `FPWM_OFS_CFG, 32'h1, 4'hf);
        repeat (4) @(posedge clk_sys);
        hi_cnt(2 * PER);
        check(h, 0);
        bus(1'b1, `FPWM_OFS_CFG, 32'h20, 4'hf);
        repeat (3) @(posedge clk_sys);
        hi_cnt(STC - 20);
        check(h, STC - 20);
        @(posedge clk_sys);
        temp_level_in <= 8'h80;
        bus(1'b1, `FPWM_OFS_DUTY, 32'h5, 4'hf);
        repeat (STC + 3 * GTC) @(posedge clk_sys);
        hi_cnt(PER);
        check(h, hi_of(160));
        bus(1'b0, `FPWM_OFS_STAT, 0, 4'hf);
        check(q, 32'h0);
        check(fan_fault_n_out, 1'b1);
        bus(1'b0, `FPWM_OFS_RPM, 0, 4'hf);
        check(q == 32'd360 || q == 32'd390, 1'b1);
        @(posedge clk_sys);
        stall <= 1'b1;
        repeat (3 * GTC) @(posedge clk_sys);
        bus(1'b0, `FPWM_OFS_STAT, 0, 4'hf);
        check(q, 32'h1);
        check(fan_fault_n_out, 1'b0);
        hi_cnt(PER);
        check(h, hi_of(160));
        @(posedge clk_sys);
        stall <= 1'b0;
        temp_level_in <= 8'ha7;
        repeat (3 * GTC) @(posedge clk_sys);
        bus(1'b0, `FPWM_OFS_STAT, 0, 4'hf);
        check(q, 32'h20);
        check(fan_fault_n_out, 1'b0);
        @(posedge clk_sys);
        temp_level_in <= 8'ha6;
        repeat (5) @(posedge clk_sys);
        bus(1'b0, `FPWM_OFS_STAT, 0, 4'hf);
        check(q, 32'h0);
        check(fan_fault_n_out, 1'b1);
        complete_run();
    end
endmodule : fan_pwm_startup_fault_ctrl_bench

// ===== tb/fpwm_fan_model.sv
// Fan model: rotor behind the drive switch and its tach sense line
module fpwm_fan_model #(
    parameter int HALF = 4
) (
    input  wire logic clk_sys,
    input  wire logic pwm_drive_out,
    input  wire logic stall,
    output logic      tach_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int   cnt_q;
    logic spin_q;
    // ---------------------------------------------
    // Rotor
    // ---------------------------------------------
    // A high drive turns the switch on; inertia carries the rotor
    always @(posedge clk_sys) begin
        if (stall) begin
            spin_q <= 1'b0;
        end else if (pwm_drive_out === 1'b1) begin
            spin_q <= 1'b1;
        end
    end
    // A stopped rotor leaves the line at its pull-up level
    always @(posedge clk_sys) begin
        if (!spin_q || stall) begin
            tach_out <= 1'b1;
            cnt_q    <= 0;
        end else if (cnt_q == HALF - 1) begin
            tach_out <= !tach_out;
            cnt_q    <= 0;
        end else begin
            cnt_q <= cnt_q + 1;
        end
    end
    initial tach_out = 1'b1;
    initial spin_q = 1'b0;
    initial cnt_q = 0;
endmodule : fpwm_fan_model
